// ===== rtl/rtcc_consts.vh
// Contract
// - Counter runs in standby only while the run-in-standby bit is one.
// - Divider field bits 6:3 divides timebase clock by two to its value.
// - New divider takes effect after two timebase clock cycles.
// - Control A bit 0 enables the counter; resets to zero.
// - Status bit 3 is one while a compare write is synchronizing.
// - Status bit 2 is one while a wrap limit write is synchronizing.
// - Status bit 1 is one while a counter write is synchronizing.
// - Status bit 0 is one while control A synchronizes; status read-only.
// - Interrupt enable bit 1 enables compare match interrupt; resets zero.
// - Interrupt enable bit 0 enables wrap interrupt; resets zero.
// - Flag bit 1 sets when counter value equals compare value.
// - Flag bit 0 sets when counter reaches wrap limit and returns to zero.
// - Writing one to a flag clears it; writing zero leaves it.
// - One shared eight-bit byte latch, software readable and writable.
// - Interrupt asserted while enable and flag both set, until cleared.
`ifndef RTCC_CONSTS_VH
`define RTCC_CONSTS_VH

// ==========================================================================
// Register indices; byte address is four times the index.
`define RTCC_IDX_RTC_CONTROL_A      5'h00
`define RTCC_IDX_STATUS     5'h01
`define RTCC_IDX_INTEN      5'h02
`define RTCC_IDX_FLAGS      5'h03
`define RTCC_IDX_LATCH      5'h04
`define RTCC_IDX_CNT_LO     5'h08
`define RTCC_IDX_CNT_HI     5'h09
`define RTCC_IDX_PER_LO     5'h0a
`define RTCC_IDX_PER_HI     5'h0b
`define RTCC_IDX_CMP_LO     5'h0c
`define RTCC_IDX_CMP_HI     5'h0d

// ==========================================================================
// Field positions.
`define RTCC_BIT_RUNSTBY    7
`define RTCC_DIV_HI         6
`define RTCC_DIV_LO         3
`define RTCC_BIT_ENABLE     0
`define RTCC_BIT_CMP        1
`define RTCC_BIT_WRAP       0
`define RTCC_CH_CMP         3
`define RTCC_CH_PER         2
`define RTCC_CH_CNT         1
`define RTCC_CH_RTC_CONTROL_A       0

// ==========================================================================
// Reset values and timing.
`define RTCC_RST_BYTE       8'h00
`define RTCC_RST_CNT        16'h0000
`define RTCC_RST_PER        16'hffff
`define RTCC_RST_CMP        16'h0000
`define RTCC_SYNC_TICKS     2'h2

`endif

// ===== rtl/rtcc_regs.v
`timescale 1ns/1ps
`include "rtcc_consts.vh"

module rtcc_regs (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // Timebase clock and sleep state
    input  wire        timebaseClk,
    input  wire        standbySleep,
    // Outputs
    output wire        irq,
    output wire        counterRunning,
    output reg  [15:0] counterValue
);

    // ======================================================================
    // Functions.
    function [14:0] divMask;
        input [3:0] div;
        integer k;
        begin
            divMask = 15'h0000;
            for (k = 0; k < 15; k = k + 1) begin
                if (k < div) begin
                    divMask[k] = 1'b1;
                end
            end
        end
    endfunction

    // Register select: a live bus phase aimed at one index.
    function regHit;
        input       en;
        input [4:0] idx;
        input [4:0] want;
        begin
            regHit = en & (idx == want);
        end
    endfunction

    // ======================================================================
    // Bus address phase capture.
    reg        dValid;
    reg        dWrite;
    reg  [4:0] dIdx;
    reg        rdDone;
    wire       addrTake = hsel & htrans[1] & hready;
    wire       dRead    = dValid & ~dWrite;

    // A read holds one wait state so that it sees any write just before it.
    assign hreadyout = ~(dRead & ~rdDone);
    assign hresp     = 1'b0;

    always @(posedge ref_clk) begin
        if (rst) begin
            dValid <= 1'b0;
            dWrite <= 1'b0;
            dIdx   <= 5'h00;
        end else if (hreadyout) begin
            dValid <= addrTake;
            dWrite <= hwrite;
            dIdx   <= haddr[6:2];
        end
    end

    // The wait state lasts exactly one cycle.
    always @(posedge ref_clk) begin
        if (rst) begin
            rdDone <= 1'b0;
        end else begin
            rdDone <= ~hreadyout;
        end
    end

    // A write lands at the end of its data phase; a read loads hrdata at
    // the end of its wait state.
    wire       wrEn   = dValid & dWrite;
    wire       rdEn   = dRead & ~rdDone;
    wire [7:0] wrByte = hwdata[7:0];

    // ======================================================================
    // Timebase input synchroniser and tick.
    // Two flops settle the slow clock before any logic reads it; the third
    // only remembers the last level for edge detection.
    reg tbMeta;
    reg tbSync;
    reg tbLast;
    always @(posedge ref_clk) begin
        if (rst) begin
            tbMeta <= 1'b0;
            tbSync <= 1'b0;
            tbLast <= 1'b0;
        end else begin
            tbMeta <= timebaseClk;
            tbSync <= tbMeta;
            tbLast <= tbSync;
        end
    end
    wire tbTick = tbSync & ~tbLast;

    // ======================================================================
    // Software-side registers.
    reg  [7:0]  rtc_control_a;
    reg  [7:0]  intEn;
    reg  [7:0]  byteLatch;
    wire [1:0]  flags;
    reg  [15:0] swCnt;
    reg  [15:0] swPer;
    reg  [15:0] swCmp;
    wire [3:0]  syncBusy;
    wire [3:0]  syncWr;
    wire [3:0]  syncApply;

    // Only the high byte write starts a transfer; the low byte waits.
    assign syncWr[`RTCC_CH_RTC_CONTROL_A] = regHit(wrEn, dIdx, `RTCC_IDX_RTC_CONTROL_A);
    assign syncWr[`RTCC_CH_CNT]   = regHit(wrEn, dIdx, `RTCC_IDX_CNT_HI);
    assign syncWr[`RTCC_CH_PER]   = regHit(wrEn, dIdx, `RTCC_IDX_PER_HI);
    assign syncWr[`RTCC_CH_CMP]   = regHit(wrEn, dIdx, `RTCC_IDX_CMP_HI);

    // ======================================================================
    // Synchronisation busy channels.
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gSync
            // Restarting the count on a rewrite keeps a newer value from
            // landing only one tick after its write.
            reg       busyQ;
            reg [1:0] tickCnt;
            assign syncBusy[g]  = busyQ;
            assign syncApply[g] = busyQ & tbTick &
                                  (tickCnt == `RTCC_SYNC_TICKS - 2'h1);
            always @(posedge ref_clk) begin
                if (rst) begin
                    busyQ   <= 1'b0;
                    tickCnt <= 2'h0;
                end else if (syncWr[g]) begin
                    busyQ   <= 1'b1;
                    tickCnt <= 2'h0;
                end else if (syncApply[g]) begin
                    busyQ <= 1'b0;
                end else if (busyQ & tbTick) begin
                    tickCnt <= tickCnt + 2'h1;
                end
            end
        end
    endgenerate

    // ======================================================================
    // Timebase-side effective copies and counter.
    reg  [7:0]  effCtrl;
    reg  [15:0] effPer;
    reg  [15:0] effCmp;
    reg  [14:0] preCnt;
    wire [3:0]  effDiv  = effCtrl[`RTCC_DIV_HI:`RTCC_DIV_LO];
    wire [14:0] preMask = divMask(effDiv);
    wire        preTick = tbTick & ((preCnt & preMask) == preMask);
    wire        stbyOk  = ~standbySleep | effCtrl[`RTCC_BIT_RUNSTBY];
    wire        cntStep;
    wire        atWrap  = (counterValue == effPer);
    wire        evWrap;
    wire        evCmp;

    assign counterRunning = effCtrl[`RTCC_BIT_ENABLE] & stbyOk;
    assign cntStep = counterRunning & preTick;
    assign evWrap  = cntStep & atWrap;
    assign evCmp   = counterRunning & preTick & (counterValue == effCmp);

    // Copies land only on an apply edge, two ticks after the write.
    always @(posedge ref_clk) begin
        if (rst) begin
            effCtrl <= `RTCC_RST_BYTE;
            effPer  <= `RTCC_RST_PER;
            effCmp  <= `RTCC_RST_CMP;
        end else begin
            if (syncApply[`RTCC_CH_RTC_CONTROL_A]) begin
                effCtrl <= rtc_control_a;
            end
            if (syncApply[`RTCC_CH_PER]) begin
                effPer <= swPer;
            end
            if (syncApply[`RTCC_CH_CMP]) begin
                effCmp <= swCmp;
            end
        end
    end

    // The prescaler restarts whenever the counter stops, so a divider
    // set while the counter is stopped counts from a clean phase.
    always @(posedge ref_clk) begin
        if (rst) begin
            preCnt <= 15'h0000;
        end else if (~counterRunning) begin
            preCnt <= 15'h0000;
        end else if (tbTick) begin
            preCnt <= preCnt + 15'h0001;
        end
    end

    // A match is judged on the value before the step, so a match and a
    // wrap of the same count can both fire on one tick.
    always @(posedge ref_clk) begin
        if (rst) begin
            counterValue <= `RTCC_RST_CNT;
        end else if (syncApply[`RTCC_CH_CNT]) begin
            counterValue <= swCnt;
        end else if (cntStep) begin
            counterValue <= atWrap ? 16'h0000 : counterValue + 16'h0001;
        end
    end

    // ======================================================================
    // Register write decode.
    // Writes to read-only or unmapped indexes change nothing.
    wire       wrCtrl  = regHit(wrEn, dIdx, `RTCC_IDX_RTC_CONTROL_A);
    wire       wrInt   = regHit(wrEn, dIdx, `RTCC_IDX_INTEN);
    wire       wrFlags = regHit(wrEn, dIdx, `RTCC_IDX_FLAGS);
    wire       wrLo    = regHit(wrEn, dIdx, `RTCC_IDX_LATCH) |
                         regHit(wrEn, dIdx, `RTCC_IDX_CNT_LO) |
                         regHit(wrEn, dIdx, `RTCC_IDX_PER_LO) |
                         regHit(wrEn, dIdx, `RTCC_IDX_CMP_LO);
    wire [1:0] flagSet = {evCmp, evWrap};
    wire [1:0] flagClr = wrFlags ? wrByte[1:0] : 2'h0;

    // ======================================================================
    // Control and interrupt enable.
    always @(posedge ref_clk) begin
        if (rst) begin
            rtc_control_a <= `RTCC_RST_BYTE;
            intEn <= `RTCC_RST_BYTE;
        end else begin
            if (wrCtrl) begin
                // Bits 2:1 have no function and always read zero.
                rtc_control_a <= {wrByte[7:3], 2'h0, wrByte[0]};
            end
            if (wrInt) begin
                intEn <= {6'h00, wrByte[1:0]};
            end
        end
    end

    // ======================================================================
    // Interrupt flags.
    // Set wins over a clear in the same cycle, so no event is lost.
    generate
        for (g = 0; g < 2; g = g + 1) begin : gFlag
            reg flagQ;
            assign flags[g] = flagQ;
            always @(posedge ref_clk) begin
                if (rst) begin
                    flagQ <= 1'b0;
                end else if (flagSet[g]) begin
                    flagQ <= 1'b1;
                end else if (flagClr[g]) begin
                    flagQ <= 1'b0;
                end
            end
        end
    endgenerate

    // ======================================================================
    // Shared byte latch.
    reg [7:0] next_byteLatch;
    always @* begin
        next_byteLatch = byteLatch;
        if (wrLo) begin
            next_byteLatch = wrByte;
        end else if (rdEn) begin
            case (dIdx)
                `RTCC_IDX_CNT_LO: begin
                    next_byteLatch = counterValue[15:8];
                end
                `RTCC_IDX_PER_LO: begin
                    next_byteLatch = swPer[15:8];
                end
                `RTCC_IDX_CMP_LO: begin
                    next_byteLatch = swCmp[15:8];
                end
                default: begin
                    next_byteLatch = byteLatch;
                end
            endcase
        end
    end

    // Software copies of the 16-bit values. The high byte write commits
    // both bytes at once, so the timebase side never sees half a value.
    always @(posedge ref_clk) begin
        if (rst) begin
            byteLatch <= `RTCC_RST_BYTE;
            swCnt     <= `RTCC_RST_CNT;
            swPer     <= `RTCC_RST_PER;
            swCmp     <= `RTCC_RST_CMP;
        end else begin
            byteLatch <= next_byteLatch;
            if (syncWr[`RTCC_CH_CNT]) begin
                swCnt <= {wrByte, byteLatch};
            end
            if (syncWr[`RTCC_CH_PER]) begin
                swPer <= {wrByte, byteLatch};
            end
            if (syncWr[`RTCC_CH_CMP]) begin
                swCmp <= {wrByte, byteLatch};
            end
        end
    end

    // ======================================================================
    // Read data. Unmapped indexes read as zero.
    reg [31:0] next_rdData;
    always @* begin
        next_rdData = 32'h00000000;
        case (dIdx)
            `RTCC_IDX_RTC_CONTROL_A: begin
                next_rdData[7:0] = rtc_control_a;
            end
            `RTCC_IDX_STATUS: begin
                next_rdData[3:0] = syncBusy;
            end
            `RTCC_IDX_INTEN: begin
                next_rdData[7:0] = intEn;
            end
            `RTCC_IDX_FLAGS: begin
                next_rdData[1:0] = flags;
            end
            `RTCC_IDX_LATCH: begin
                next_rdData[7:0] = byteLatch;
            end
            `RTCC_IDX_CNT_LO: begin
                next_rdData[7:0] = counterValue[7:0];
            end
            `RTCC_IDX_PER_LO: begin
                next_rdData[7:0] = swPer[7:0];
            end
            `RTCC_IDX_CMP_LO: begin
                next_rdData[7:0] = swCmp[7:0];
            end
            `RTCC_IDX_CNT_HI,
            `RTCC_IDX_PER_HI,
            `RTCC_IDX_CMP_HI: begin
                next_rdData[7:0] = byteLatch;
            end
            default: begin
                next_rdData = 32'h00000000;
            end
        endcase
    end

    // Data stand from the load until the next read replaces them.
    always @(posedge ref_clk) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (rdEn) begin
            hrdata <= next_rdData;
        end
    end

    // ======================================================================
    // Interrupt output.
    wire [1:0] irqSrc = flags & intEn[1:0];
    assign irq = |irqSrc;

endmodule // rtcc_regs

// ===== verif/rtcc_regs_props.sv
`timescale 1ns/1ps
// ==========================================================================
// Port watcher. Shadows keep the old value too, since a write lands late.
module rtcc_props (
    // Clock and reset
    input wire        ref_clk,
    input wire        rst,
    // Bus
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    // Timer side
    input wire        standbySleep,
    input wire        irq,
    input wire        counterRunning,
    input wire [15:0] counterValue
);
    logic       aPh, aWr, cntW, enSh, enOld, runSh, runOld;
    logic [4:0] aIdx;
    wire        wrPh = aPh & aWr & hready;
    wire        rdPh = aPh & ~aWr;

    always @(posedge ref_clk) begin
        if (rst) begin
            {aPh, aWr, cntW, enSh, enOld, runSh, runOld} <= 7'h00;
            aIdx <= 5'h00;
        end else begin
            if (hready) begin
                aPh <= hsel & htrans[1];
                aWr <= hwrite;
                aIdx <= haddr[6:2];
            end
            if (wrPh && aIdx == 5'h00) begin
                {enOld, runOld} <= {enSh, runSh};
                {enSh, runSh} <= {hwdata[0], hwdata[7]};
            end
            if (wrPh && aIdx[4:1] == 4'h4)
                cntW <= 1'b1;
        end
    end

    // ======================================================================
    // Properties.
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_rdWait;
        rdPh && !hreadyout;
    endsequence
    property p_rdWait;
        s_rdWait |=> hreadyout;
    endproperty
    property p_wrNoWait;
        aPh && aWr |-> hreadyout;
    endproperty
    property p_irqFall;
        $fell(irq) |-> $past(wrPh);
    endproperty
    property p_irqRise;
        $rose(irq) |-> $past(wrPh || counterRunning);
    endproperty
    property p_step;
        $changed(counterValue) && !cntW |->
            counterValue == $past(counterValue) + 16'h1 || counterValue == 16'h0;
    endproperty
    property p_resetIdle;
        $fell(rst) |-> (!counterRunning && !irq) [*3];
    endproperty
    property p_enable;
        counterRunning |-> enSh || enOld;
    endproperty
    property p_standby;
        counterRunning && standbySleep && $past(standbySleep, 2)
            |-> runSh || runOld;
    endproperty
    a_rdWait: assert property (p_rdWait) else $error("read wait");
    a_wrNoWait: assert property (p_wrNoWait) else $error("write wait");
    a_irqFall: assert property (p_irqFall) else $error("irq fell");
    a_irqRise: assert property (p_irqRise) else $error("irq rose");
    a_step: assert property (p_step) else $error("counter step");
    a_resetIdle: assert property (p_resetIdle) else $error("reset");
    a_enable: assert property (p_enable) else $error("enable");
    a_standby: assert property (p_standby) else $error("standby");
endmodule // rtcc_props

bind rtcc_regs rtcc_props u_props (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .standbySleep(standbySleep),
    .irq(irq), .counterRunning(counterRunning), .counterValue(counterValue));

// ===== verif/rtc_ctrl_status_irq_regs_test.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench of the timer register front end.
module rtc_ctrl_status_irq_regs_test;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        timebaseClk = 1'b0;
    logic        standbySleep = 1'b0;
    logic [2:0]  tbDiv = 3'h0;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, irq, counterRunning;
    wire  [15:0] counterValue;
    int          errTotal = 0, testsRun = 0, cyc = 0, n, dv;
    logic [31:0] q;
    logic [15:0] v;
    logic [4:0]  bi [4] = '{5'h00, 5'h09, 5'h0b, 5'h0d};

    rtcc_regs i_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .timebaseClk(timebaseClk), .standbySleep(standbySleep),
        .irq(irq), .counterRunning(counterRunning),
        .counterValue(counterValue));

    initial forever #25 ref_clk = ~ref_clk;
    // Timebase of exactly eight bus cycles, so step spacing is exact.
    always @(posedge ref_clk) begin
        tbDiv <= tbDiv + 3'h1;
        timebaseClk <= tbDiv[2];
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errTotal++;
            endOfTest;
        end
    end

    // ======================================================================
    // Tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [4:0] i, input logic [7:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {25'h0, i, 2'h0};
        do @(negedge ref_clk); while (!hreadyout);
        @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(negedge ref_clk); while (!hreadyout);
        q = hrdata;
    endtask
    task automatic wr(input logic [4:0] i, input logic [7:0] d);
        xfer(1'b1, i, d);
    endtask
    task automatic rc(input logic [4:0] i, input logic [31:0] e);
        xfer(1'b0, i, 8'h00);
        chk(q, e);
    endtask
    task automatic waitIdle;
        do xfer(1'b0, 5'h01, 8'h00); while (q[3:0] !== 4'h0);
    endtask
    task automatic gap(output int k);
        logic [15:0] c;
        k = 0;
        c = counterValue;
        while (counterValue === c) @(negedge ref_clk);
        c = counterValue;
        while (counterValue === c) begin
            @(negedge ref_clk);
            k++;
        end
    endtask
    task automatic endOfTest;
        $display("compares %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ======================================================================
    // Sequence.
    initial begin
        n = $urandom(32'hfdac);
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        for (n = 0; n < 7; n++) rc(n[4:0], 32'h0);
        chk(hresp, 1'b0);
        wr(5'h01, 8'hff);
        rc(5'h01, 32'h0);
        v = $urandom;
        wr(5'h04, v[7:0]);
        rc(5'h04, {24'h0, v[7:0]});
        $display("test reset ends");
        dv = $urandom_range(3, 0);
        wr(5'h0a, 8'h03);
        wr(5'h0b, 8'h00);
        wr(5'h0c, 8'h02);
        wr(5'h0d, 8'h00);
        wr(5'h02, 8'h02);
        wr(5'h00, {1'b0, dv[3:0], 3'h1});
        waitIdle;
        gap(n);
        chk(n, 8 << dv);
        for (n = 0; n < 600 && irq !== 1'b1; n++) @(negedge ref_clk);
        chk(irq, 1'b1);
        repeat (300) @(negedge ref_clk);
        wr(5'h00, 8'h00);
        waitIdle;
        rc(5'h03, 32'h3);
        chk(counterValue <= 16'h3, 1'b1);
        wr(5'h03, 8'h00);
        rc(5'h03, 32'h3);
        chk(irq, 1'b1);
        wr(5'h02, 8'h00);
        rc(5'h02, 32'h0);
        chk(irq, 1'b0);
        wr(5'h02, 8'h01);
        rc(5'h02, 32'h1);
        chk(irq, 1'b1);
        wr(5'h03, 8'h03);
        rc(5'h03, 32'h0);
        chk(irq, 1'b0);
        $display("test counter ends");
        wr(5'h00, 8'h01);
        waitIdle;
        @(posedge ref_clk) standbySleep <= 1'b1;
        repeat (4) @(negedge ref_clk);
        chk(counterRunning, 1'b0);
        wr(5'h00, 8'h81);
        waitIdle;
        chk(counterRunning, 1'b1);
        @(posedge ref_clk) standbySleep <= 1'b0;
        v = $urandom;
        wr(5'h0c, v[7:0]);
        wr(5'h0d, v[15:8]);
        waitIdle;
        rc(5'h0c, {24'h0, v[7:0]});
        rc(5'h0d, {24'h0, v[15:8]});
        $display("test standby and pairing ends");
        for (n = 0; n < 4; n++) begin
            wr(bi[n], 8'h00);
            rc(5'h01, 32'h1 << n);
            waitIdle;
        end
        $display("test busy ends");
        endOfTest;
    end
endmodule // rtc_ctrl_status_irq_regs_test
